// ### verilog/awm_regs.svh
// register map, field positions and timing constants of the auto window monitor
// Function
// - enable bit 7 of control runs interval counter; clearing stops auto conversions
// - 3-bit interval select picks 4,8,16,...,512 ms, doubling per code
// - at period match with converter_power_enable set and no conversion busy, converter is powered up and one conversion starts
// - result outside limits increments the 3-bit out-of-range count by one
// - count equal to threshold raises interrupt request and clears count
// - threshold codes 00,01,10,11 mean 1,2,4,7 events
// - counting, comparing and event counting continue during CPU idle or sleep
// - auto-conversion interrupt can wake the CPU
// - control bit 5 zero enables amp turn-on timing, one disables it
// - upper limit: bits 11..4 in high byte, bits 3..0 in low bits 7..4
// - lower limit uses the same split across its two registers
// - unimplemented bits read zero and ignore writes
// - compared value is the 12-bit converter result, full scale FFF
`ifndef AWM_REGS_SVH
`define AWM_REGS_SVH

`define AWM_OFS_CTRL 8'h00
`define AWM_OFS_EVT 8'h04
`define AWM_OFS_UP_LO 8'h08
`define AWM_OFS_UP_HI 8'h0C
`define AWM_OFS_LO_LO 8'h10
`define AWM_OFS_LO_HI 8'h14
`define AWM_OFS_STAT 8'h18
`define AWM_OFS_MASK 8'h1C
`define AWM_OFS_RESULT 8'h20

`define AWM_CTRL_EN_BIT 7
`define AWM_CTRL_AMP_BIT 5
`define AWM_CTRL_IVL_MSB 2
`define AWM_CTRL_IVL_LSB 0
`define AWM_EVT_CNT_MSB 6
`define AWM_EVT_CNT_LSB 4
`define AWM_EVT_THR_MSB 1
`define AWM_EVT_THR_LSB 0
`define AWM_LIM_LO_MSB 7
`define AWM_LIM_LO_LSB 4
`define AWM_LIM_HI_MSB 7
`define AWM_LIM_HI_LSB 0
`define AWM_IRQ_WIN_BIT 0
`define AWM_IRQ_DONE_BIT 1
`define AWM_RES_MSB 11
`define AWM_RES_LSB 0

`define AWM_HTRANS_NONSEQ 2'h2
`define AWM_RESET_BYTE 8'h00
`define AWM_BASE_MS 10'h004
`define AWM_THR_CODE0 3'h1
`define AWM_THR_CODE1 3'h2
`define AWM_THR_CODE2 3'h4
`define AWM_THR_CODE3 3'h7
`define AWM_FULL_SCALE 12'hFFF

`define AWM_CLK_NS 10
`define AWM_MS_NS 1000000
`define AWM_MS_CYCLES (`AWM_MS_NS / `AWM_CLK_NS)
`define AWM_SETTLE_NS 2000
`define AWM_SETTLE_CYCLES ((`AWM_SETTLE_NS + `AWM_CLK_NS - 1) / `AWM_CLK_NS)

`endif

// ### verilog/awm_pkg.sv
// types shared by the auto window monitor modules
package awm_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} awm_phase_t;

  typedef struct packed {
    logic power_up;
    logic start;
  } awm_adc_req_t;

  typedef struct packed {
    logic done;
    logic [11:0] result;
  } awm_adc_rsp_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } awm_tick_st_t;

  typedef struct packed {
    logic auto_en;
    logic amp_dis;
    logic [2:0] ivl_sel;
    logic [2:0] evt_cnt;
    logic [1:0] thr_sel;
    logic [3:0] up_lo;
    logic [7:0] up_hi;
    logic [3:0] lo_lo;
    logic [7:0] lo_hi;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [11:0] last_result;
    logic [9:0] ms_cnt;
    awm_phase_t phase;
    logic [7:0] settle_cnt;
    logic adc_start;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } awm_state_t;

endpackage : awm_pkg

// ### verilog/awm_ms_tick.sv
// millisecond enable pulse divider for the interval counter
`include "awm_regs.svh"

module awm_ms_tick #(
  parameter int unsigned CYCLES = `AWM_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic restart,
  output logic tick
);
  import awm_pkg::*;

  awm_tick_st_t s_ff;
  awm_tick_st_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (restart)
    begin
      nxt_s.cnt = '0;
    end
    else if (s_ff.cnt == 32'(CYCLES - 1))
    begin
      nxt_s.cnt = '0;
      nxt_s.tick = 1'b1;
    end
    else
    begin
      nxt_s.cnt = s_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

endmodule : awm_ms_tick

// ### verilog/awm_window_monitor.sv
// periodic converter sequencer with window compare, event count and ahb-lite registers
`include "awm_regs.svh"

module awm_window_monitor #(
  parameter int unsigned MS_CYCLES = `AWM_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic converter_power_enable,
  output awm_pkg::awm_adc_req_t adc_req,
  input wire awm_pkg::awm_adc_rsp_t adc_rsp,
  output logic irq
);
  import awm_pkg::*;

  localparam int SETTLE_N = `AWM_SETTLE_CYCLES;

  awm_state_t s_ff;
  awm_state_t nxt_s;
  logic ms_tick;
  logic ivl_restart;
  logic [9:0] period;
  logic [11:0] upper;
  logic [11:0] lower;
  logic out_of_range;
  logic [2:0] thr_count;
  logic [2:0] cnt_inc;
  logic trigger;
  logic aph_valid;
  logic rd_stat;
  logic [1:0] irq_set;

  function automatic logic [31:0] read_mux(input awm_state_t st, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      `AWM_OFS_CTRL:
      begin
        r[`AWM_CTRL_EN_BIT] = st.auto_en;
        r[`AWM_CTRL_AMP_BIT] = st.amp_dis;
        r[`AWM_CTRL_IVL_MSB:`AWM_CTRL_IVL_LSB] = st.ivl_sel;
      end
      `AWM_OFS_EVT:
      begin
        r[`AWM_EVT_CNT_MSB:`AWM_EVT_CNT_LSB] = st.evt_cnt;
        r[`AWM_EVT_THR_MSB:`AWM_EVT_THR_LSB] = st.thr_sel;
      end
      `AWM_OFS_UP_LO: r[`AWM_LIM_LO_MSB:`AWM_LIM_LO_LSB] = st.up_lo;
      `AWM_OFS_UP_HI: r[`AWM_LIM_HI_MSB:`AWM_LIM_HI_LSB] = st.up_hi;
      `AWM_OFS_LO_LO: r[`AWM_LIM_LO_MSB:`AWM_LIM_LO_LSB] = st.lo_lo;
      `AWM_OFS_LO_HI: r[`AWM_LIM_HI_MSB:`AWM_LIM_HI_LSB] = st.lo_hi;
      `AWM_OFS_MASK:
      begin
        r[`AWM_IRQ_DONE_BIT] = st.irq_mask[`AWM_IRQ_DONE_BIT];
        r[`AWM_IRQ_WIN_BIT] = st.irq_mask[`AWM_IRQ_WIN_BIT];
      end
      `AWM_OFS_RESULT: r[`AWM_RES_MSB:`AWM_RES_LSB] = st.last_result;
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  // the divider restarts together with the interval counter so the first
  // period after enabling is a full one
  awm_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_ms_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(ivl_restart),
    .tick(ms_tick)
  );

  always_comb
  begin
    period = `AWM_BASE_MS << s_ff.ivl_sel;
    upper = {s_ff.up_hi, s_ff.up_lo};
    lower = {s_ff.lo_hi, s_ff.lo_lo};
    // plain unsigned compare, equality counts as inside
    out_of_range = (adc_rsp.result > upper) || (adc_rsp.result < lower);
    case (s_ff.thr_sel)
      2'h0: thr_count = `AWM_THR_CODE0;
      2'h1: thr_count = `AWM_THR_CODE1;
      2'h2: thr_count = `AWM_THR_CODE2;
      default: thr_count = `AWM_THR_CODE3;
    endcase
    cnt_inc = s_ff.evt_cnt + 3'h1;
    aph_valid = hsel && hready && (htrans == `AWM_HTRANS_NONSEQ);
    rd_stat = aph_valid && !hwrite && (haddr[7:0] == `AWM_OFS_STAT);
  end

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.adc_start = 1'b0;
    ivl_restart = !s_ff.auto_en;
    irq_set = 2'h0;
    trigger = 1'b0;

    // data phase of a write: only implemented bits are stored
    if (s_ff.dph_wr)
    begin
      case (s_ff.dph_addr)
        `AWM_OFS_CTRL:
        begin
          nxt_s.auto_en = hwdata[`AWM_CTRL_EN_BIT];
          nxt_s.amp_dis = hwdata[`AWM_CTRL_AMP_BIT];
          nxt_s.ivl_sel = hwdata[`AWM_CTRL_IVL_MSB:`AWM_CTRL_IVL_LSB];
          ivl_restart = 1'b1;
        end
        `AWM_OFS_EVT:
        begin
          nxt_s.evt_cnt = hwdata[`AWM_EVT_CNT_MSB:`AWM_EVT_CNT_LSB];
          nxt_s.thr_sel = hwdata[`AWM_EVT_THR_MSB:`AWM_EVT_THR_LSB];
        end
        `AWM_OFS_UP_LO: nxt_s.up_lo = hwdata[`AWM_LIM_LO_MSB:`AWM_LIM_LO_LSB];
        `AWM_OFS_UP_HI: nxt_s.up_hi = hwdata[`AWM_LIM_HI_MSB:`AWM_LIM_HI_LSB];
        `AWM_OFS_LO_LO: nxt_s.lo_lo = hwdata[`AWM_LIM_LO_MSB:`AWM_LIM_LO_LSB];
        `AWM_OFS_LO_HI: nxt_s.lo_hi = hwdata[`AWM_LIM_HI_MSB:`AWM_LIM_HI_LSB];
        `AWM_OFS_MASK:
        begin
          nxt_s.irq_mask[`AWM_IRQ_WIN_BIT] = hwdata[`AWM_IRQ_WIN_BIT];
          nxt_s.irq_mask[`AWM_IRQ_DONE_BIT] = hwdata[`AWM_IRQ_DONE_BIT];
        end
        default: nxt_s.irq_mask = s_ff.irq_mask;
      endcase
    end

    // interval counter in milliseconds; no sleep input exists, so it keeps
    // running whatever the cpu is doing
    if (ivl_restart)
    begin
      nxt_s.ms_cnt = '0;
    end
    else if (ms_tick)
    begin
      if (10'(s_ff.ms_cnt + 10'h001) == period)
      begin
        nxt_s.ms_cnt = '0;
        // a match while the previous conversion is still busy is skipped
        trigger = (s_ff.phase == ST_IDLE) && converter_power_enable;
      end
      else
      begin
        nxt_s.ms_cnt = 10'(s_ff.ms_cnt + 10'h001);
      end
    end

    case (s_ff.phase)
      ST_IDLE:
      begin
        if (trigger)
        begin
          nxt_s.settle_cnt = '0;
          if (s_ff.amp_dis)
          begin
            nxt_s.adc_start = 1'b1;
            nxt_s.phase = ST_CONVERT;
          end
          else
          begin
            nxt_s.phase = ST_SETTLE;
          end
        end
      end
      ST_SETTLE:
      begin
        // amplifier and converter warm up before the start strobe
        if (!s_ff.auto_en)
        begin
          nxt_s.phase = ST_IDLE;
        end
        else if (s_ff.settle_cnt == 8'(SETTLE_N - 1))
        begin
          nxt_s.adc_start = 1'b1;
          nxt_s.phase = ST_CONVERT;
        end
        else
        begin
          nxt_s.settle_cnt = s_ff.settle_cnt + 8'h01;
        end
      end
      ST_CONVERT:
      begin
        // a started conversion is allowed to finish even if disabled meanwhile
        if (adc_rsp.done)
        begin
          nxt_s.phase = ST_IDLE;
          nxt_s.last_result = adc_rsp.result;
          irq_set[`AWM_IRQ_DONE_BIT] = 1'b1;
          if (out_of_range)
          begin
            if (cnt_inc == thr_count)
            begin
              nxt_s.evt_cnt = '0;
              irq_set[`AWM_IRQ_WIN_BIT] = 1'b1;
            end
            else
            begin
              nxt_s.evt_cnt = cnt_inc;
            end
          end
        end
      end
      default: nxt_s.phase = ST_IDLE;
    endcase

    // read clears status; an event in the same cycle survives the clear
    nxt_s.irq_stat = (rd_stat ? 2'h0 : s_ff.irq_stat) | irq_set;

    nxt_s.dph_wr = aph_valid && hwrite;
    if (aph_valid)
    begin
      nxt_s.dph_addr = haddr[7:0];
    end
    if (aph_valid && !hwrite)
    begin
      // reading the next-state copy makes a read right after a write see it
      if (haddr[7:0] == `AWM_OFS_STAT)
      begin
        nxt_s.rdata = {30'h0, s_ff.irq_stat};
      end
      else
      begin
        nxt_s.rdata = read_mux(nxt_s, haddr[7:0]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_ff <= '0;
      s_ff.phase <= ST_IDLE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_ff.rdata;
  assign adc_req.power_up = (s_ff.phase != ST_IDLE);
  assign adc_req.start = s_ff.adc_start;
  // level output that doubles as the wake request to the cpu
  assign irq = |(s_ff.irq_stat & s_ff.irq_mask);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence settle_phase;
    (s_ff.phase == ST_SETTLE) && s_ff.auto_en;
  endsequence

  sequence start_strobe;
    adc_req.start && (s_ff.phase == ST_CONVERT);
  endsequence

  a_off_stays_idle: assert property (
    (!s_ff.auto_en && (s_ff.phase == ST_IDLE) && !s_ff.dph_wr) |=> (s_ff.phase == ST_IDLE)
  ) else $error("conversion started while disabled");

  a_ms_below_period: assert property (
    (s_ff.auto_en && !$past(s_ff.dph_wr)) |-> (s_ff.ms_cnt < period)
  ) else $error("interval counter beyond selected period");

  a_trigger_powers: assert property (
    trigger |=> adc_req.power_up && (s_ff.ms_cnt == 10'h000)
  ) else $error("period match did not power the converter");

  a_trigger_needs_power: assert property (
    trigger |-> converter_power_enable
  ) else $error("conversion triggered without converter power");

  a_amp_skip: assert property (
    (trigger && s_ff.amp_dis) |=> start_strobe
  ) else $error("start not immediate with timing control off");

  a_amp_settle: assert property (
    (trigger && !s_ff.amp_dis) |=> settle_phase ##1 !adc_req.start [*8]
  ) else $error("start issued without warm-up");

  a_settle_bound: assert property (
    settle_phase |-> ##[0:SETTLE_N] !settle_phase
  ) else $error("warm-up does not end in time");

  a_count_step: assert property (
    ((s_ff.phase == ST_CONVERT) && adc_rsp.done && out_of_range && (cnt_inc != thr_count))
      |=> (s_ff.evt_cnt == $past(cnt_inc))
  ) else $error("out-of-range count not incremented by one");

  a_in_range_hold: assert property (
    ((s_ff.phase == ST_CONVERT) && adc_rsp.done && !out_of_range
      && !(s_ff.dph_wr && (s_ff.dph_addr == `AWM_OFS_EVT))) |=> $stable(s_ff.evt_cnt)
  ) else $error("in-range result changed the count");

  a_thr_fire: assert property (
    ((s_ff.phase == ST_CONVERT) && adc_rsp.done && out_of_range && (cnt_inc == thr_count))
      |=> (s_ff.evt_cnt == 3'h0) && s_ff.irq_stat[`AWM_IRQ_WIN_BIT]
  ) else $error("threshold reached without interrupt and clear");

  a_irq_wakes: assert property (
    (s_ff.irq_stat[`AWM_IRQ_WIN_BIT] && s_ff.irq_mask[`AWM_IRQ_WIN_BIT] && !rd_stat
      && !(s_ff.dph_wr && (s_ff.dph_addr == `AWM_OFS_MASK))) |=> irq
  ) else $error("masked-in window event does not hold interrupt");

  a_rsv_zero: assert property (
    hrdata[31:12] == 20'h00000
  ) else $error("unimplemented read bits not zero");

endmodule : awm_window_monitor

// ### tb/awm_adc_model.sv
// behavioural converter that answers start pulses after a chosen delay
module awm_adc_model (
  input wire logic sys_clk,
  input wire awm_pkg::awm_adc_req_t adc_req,
  input wire logic [11:0] res,
  input wire logic [7:0] lat,
  output awm_pkg::awm_adc_rsp_t adc_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import awm_pkg::*;
  int wait_cnt = -1;
  initial adc_rsp = '0;
  // an unpowered converter never answers; result toggles outside done
  always @(posedge sys_clk)
  begin
    if (wait_cnt == 0)
      adc_rsp <= {1'b1, res};
    else
      adc_rsp <= {1'b0, ~adc_rsp.result};
    if (adc_req.start && adc_req.power_up)
      wait_cnt <= int'(lat);
    else if (wait_cnt >= 0)
      wait_cnt <= wait_cnt - 1;
  end
endmodule : awm_adc_model

// ### tb/awm_window_monitor_test.sv
// self-checking bench for the auto window monitor
module awm_window_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import awm_pkg::*;
  localparam int MS = 10;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, irq, cpe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] res;
  logic [7:0] lat;
  awm_adc_req_t adc_req;
  awm_adc_rsp_t adc_rsp;
  int bad_count, check_count, cyc, starts, gap, t_start, t_pu, warm;
  int exp_cnt, up, lo, thr, thr_n, s;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24};
  logic [31:0] msk [7] = '{32'hA7, 32'h73, 32'hF0, 32'hFF, 32'hF0, 32'hFF, 32'h0};

  awm_window_monitor #(.MS_CYCLES(MS)) i_awm_window_monitor (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .converter_power_enable(cpe), .adc_req(adc_req), .adc_rsp(adc_rsp), .irq(irq)
  );
  awm_adc_model i_awm_adc_model (
    .sys_clk(sys_clk), .adc_req(adc_req), .res(res), .lat(lat), .adc_rsp(adc_rsp)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // start spacing and warm-up length seen at the converter link
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if ($rose(adc_req.power_up))
      t_pu <= cyc;
    if (adc_req.start)
    begin
      gap <= cyc - t_start;
      t_start <= cyc;
      starts <= starts + 1;
      warm <= cyc - t_pu;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wait_starts(input int n);
    int k;
    k = 0;
    s = starts;
    while (starts < s + n && k < 3000)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk(32'(starts >= s + n), 32'h1);
  endtask : wait_starts

  // feed one result, then compare count and interrupt with the model
  task automatic conv(input logic [11:0] v);
    int n;
    logic fired;
    n = 0;
    res <= v;
    lat <= 8'(1 + $urandom % 20);
    while (adc_rsp.done !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n < 400), 32'h1);
    if (int'(v) > up || int'(v) < lo)
      exp_cnt++;
    fired = (exp_cnt == thr_n);
    if (fired)
      exp_cnt = 0;
    wt(3);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'((exp_cnt << 4) | thr));
    chk({31'h0, irq}, {31'h0, fired});
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, {20'h0, v});
    if (fired)
    begin
      // the done bit is set by every conversion, the window bit by this one
      bus(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h3);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : conv

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    #300000;
    bad_count++;
    $display("Error at %0t: watchdog timeout", $time);
    final_report();
  end

  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cpe = 1'b0;
    res = 12'h0;
    lat = 8'h1;
    nrst = 1'b0;
    void'($urandom(32'hCD42));
    wt(4);
    nrst <= 1'b1;
    wt(1);
    foreach (offs[i])
    begin
      bus(1'b0, offs[i], 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, offs[i], 32'hFFFF_FFFF);
      bus(1'b0, offs[i], 32'h0);
      chk(rd, msk[i]);
      bus(1'b1, offs[i], 32'h0);
    end
    lo = 32'h100 + $urandom % 32'h100;
    up = 32'hC00 - $urandom % 32'h100;
    bus(1'b1, 8'h08, {24'h0, up[3:0], 4'h0});
    bus(1'b1, 8'h0C, 32'(up[11:4]));
    bus(1'b1, 8'h10, {24'h0, lo[3:0], 4'h0});
    bus(1'b1, 8'h14, 32'(lo[11:4]));
    bus(1'b1, 8'h1C, 32'h1);
    cpe <= 1'b1;
    bus(1'b1, 8'h00, 32'hA0);
    for (int t = 0; t < 4; t++)
    begin
      thr = t;
      thr_n = (t == 3) ? 7 : (1 << t);
      exp_cnt = 0;
      bus(1'b1, 8'h04, 32'(t));
      for (int k = 0; k < thr_n; k++)
      begin
        conv(12'((k % 3 == 0) ? lo : (k % 3 == 1) ? up : lo + $urandom % (up - lo)));
        if (k == 0)
          conv(12'hFFF);
        else if (k % 2 == 1)
          conv(12'(up + 1 + $urandom % (32'hFFF - up)));
        else
          conv(12'(lo - 1 - $urandom % lo));
      end
    end
    bus(1'b1, 8'h1C, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      bus(1'b1, 8'h00, 32'(8'hA0 | c));
      wait_starts(3);
      chk(32'(gap), 32'((4 << c) * MS));
    end
    bus(1'b1, 8'h00, 32'h80);
    wait_starts(2);
    chk({31'h0, warm >= 200 && warm <= 201}, 32'h1);
    bus(1'b1, 8'h00, 32'h20);
    s = starts;
    wt(300);
    chk(32'(starts), 32'(s));
    bus(1'b1, 8'h00, 32'hA0);
    cpe <= 1'b0;
    s = starts;
    wt(200);
    chk(32'(starts), 32'(s));
    final_report();
  end
endmodule : awm_window_monitor_test
